// [core/rrp_pkg.sv]
package rrp_pkg;

	// Frame and data widths
	localparam int ADDR_W    = 7;
	localparam int DATA_W    = 8;
	localparam int EVENT_W   = 16;
	localparam int NUM_PINS  = 3;
	localparam int BIT_CNT_W = 4;

	// Frame bit positions: one direction bit, seven address bits, eight data bits
	localparam logic [BIT_CNT_W-1:0] ADDR_LAST_BIT  = 4'h7;
	localparam logic [BIT_CNT_W-1:0] DATA_FIRST_BIT = 4'h8;
	localparam logic [BIT_CNT_W-1:0] DATA_LAST_BIT  = 4'hF;
	localparam int                   DIR_BIT_POS    = 6;
	localparam logic                 DIR_WRITE      = 1'b1;

	// Register map
	localparam logic [ADDR_W-1:0] ADDR_CAUSE_FIRST  = 7'h03;
	localparam logic [ADDR_W-1:0] ADDR_CAUSE_SECOND = 7'h04;
	localparam logic [ADDR_W-1:0] ADDR_ENABLE_FIRST = 7'h05;
	localparam logic [ADDR_W-1:0] ADDR_ENABLE_SECOND = 7'h06;
	localparam logic [ADDR_W-1:0] ADDR_PIN0_CFG     = 7'h0B;
	localparam logic [ADDR_W-1:0] ADDR_PIN1_CFG     = 7'h0C;
	localparam logic [ADDR_W-1:0] ADDR_PIN2_CFG     = 7'h0D;
	localparam logic [ADDR_W-1:0] ADDR_PIN_STATE    = 7'h0E;

	// Reset values
	localparam logic [DATA_W-1:0]               RST_ENABLE  = 8'h00;
	localparam logic [NUM_PINS-1:0][DATA_W-1:0] RST_PIN_CFG = {8'h07, 8'h04, 8'h00};
	localparam logic [DATA_W-1:0]               READ_NONE   = 8'h00;

	// Pin function field and codes
	localparam int         FUNC_MSB    = 2;
	localparam logic [2:0] FUNC_POR    = 3'h0;
	localparam logic [2:0] FUNC_WAKE   = 3'h1;
	localparam logic [2:0] FUNC_LOWBAT = 3'h2;
	localparam logic [2:0] FUNC_FIFO   = 3'h3;
	localparam logic [2:0] FUNC_MCUCLK = 3'h4;
	localparam logic [2:0] FUNC_DRV0   = 3'h5;
	localparam logic [2:0] FUNC_DRV1   = 3'h6;
	localparam logic [2:0] FUNC_INPUT  = 3'h7;

	// Timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int POR_TIME_PS   = 1000000;
	localparam int POR_CYCLES    = (POR_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int POR_CNT_W     = 8;
	localparam int MCU_CLK_HALF  = 4;

	// Synchroniser reset: select idles high, others low
	localparam logic [3:0] SERIAL_SYNC_RST = 4'h8;

	// Serial pins from the host
	typedef struct packed {
		logic select_n;
		logic sclk;
		logic write_in;
	} rrp_serial_in_type;

	// General-purpose pin drive
	typedef struct packed {
		logic [NUM_PINS-1:0] level;
		logic [NUM_PINS-1:0] enable;
	} rrp_pin_drive_type;

	// Serial engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ADDR = 3'b010,
		ST_DATA = 3'b100
	} rrp_state_type;

endpackage

// [core/rrp_sync.sv]
// Two-stage synchroniser for inputs from outside the clock domain
module rrp_sync #(
	parameter int              WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and control
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	input  wire logic             clk_en_i,
	// Data
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_r <= RST_VAL;
			q_o    <= RST_VAL;
		end else if (clk_en_i) begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end

endmodule

// [core/rrp_pin_mux.sv]
// Per-pin function select for the general-purpose pins
module rrp_pin_mux
	import rrp_pkg::*;
#(
	parameter int MCU_HALF = MCU_CLK_HALF
) (
	// Clock and control
	input  wire logic                                 clock_i,
	input  wire logic                                 rst_n_i,
	input  wire logic                                 clk_en_i,
	input  wire logic                                 quiet_i,
	// Configuration and sources
	input  wire logic [rrp_pkg::NUM_PINS-1:0][rrp_pkg::DATA_W-1:0] cfg_i,
	input  wire logic                                 por_active_i,
	input  wire logic                                 fifo_status_i,
	input  wire logic                                 wake_timer_i,
	input  wire logic                                 low_batt_i,
	// Pin drive
	output rrp_pkg::rrp_pin_drive_type                drive_o
);

	localparam int DIV_W = $clog2(MCU_HALF + 1);

	logic [DIV_W-1:0] div_cnt_r;
	logic             mcu_clk_r;

	// MCU clock divider, cleared with its clock low during power-down
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt_r <= '0;
			mcu_clk_r <= 1'b0;
		end else if (clk_en_i) begin
			if (quiet_i) begin
				div_cnt_r <= '0;
				mcu_clk_r <= 1'b0;
			end else if (div_cnt_r == DIV_W'(MCU_HALF - 1)) begin
				div_cnt_r <= '0;
				mcu_clk_r <= ~mcu_clk_r;
			end else begin
				div_cnt_r <= div_cnt_r + 1'b1;
			end
		end
	end

	// One registered driver per pin
	for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
		always_ff @(posedge clock_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				drive_o.level[p]  <= 1'b0;
				drive_o.enable[p] <= 1'b0;
			end else if (clk_en_i) begin
				drive_o.enable[p] <= ~quiet_i && (cfg_i[p][FUNC_MSB:0] != FUNC_INPUT);
				unique case (cfg_i[p][FUNC_MSB:0])
					FUNC_POR:    drive_o.level[p] <= por_active_i;
					FUNC_WAKE:   drive_o.level[p] <= wake_timer_i;
					FUNC_LOWBAT: drive_o.level[p] <= low_batt_i;
					FUNC_FIFO:   drive_o.level[p] <= fifo_status_i;
					FUNC_MCUCLK: drive_o.level[p] <= mcu_clk_r;
					FUNC_DRV0:   drive_o.level[p] <= 1'b0;
					FUNC_DRV1:   drive_o.level[p] <= 1'b1;
					FUNC_INPUT:  drive_o.level[p] <= 1'b0;
				endcase
			end
		end
	end

endmodule

// [core/rrp_host_port.sv]
// Host serial port, interrupt status and pin configuration
module rrp_host_port
	import rrp_pkg::*;
#(
	parameter int POR_HOLD = POR_CYCLES,
	parameter int MCU_HALF = MCU_CLK_HALF
) (
	// Clock, reset, enable
	input  wire logic                            clock_i,
	input  wire logic                            rst_b_i,
	input  wire logic                            clk_en_i,
	// Host serial bus
	input  rrp_pkg::rrp_serial_in_type           serial_i,
	output logic                                 serial_readback_out_o,
	output logic                                 serial_readback_oe_o,
	// Host interrupt and power control
	output logic                                 host_interrupt_n_o,
	input  wire logic                            power_down_in_i,
	// General-purpose pins
	input  wire logic [rrp_pkg::NUM_PINS-1:0]    gpio_in_i,
	output rrp_pkg::rrp_pin_drive_type           gpio_o,
	// Internal event and status sources
	input  wire logic [rrp_pkg::EVENT_W-1:0]     event_i,
	input  wire logic                            fifo_status_i,
	input  wire logic                            wake_timer_i,
	input  wire logic                            low_batt_i
);

	import rrp_pkg::*;

	// Reset and synchronised pins
	logic [1:0]             rst_pipe_r;
	logic                   rst_n;
	logic                   sel_n_s;
	logic                   sclk_s;
	logic                   write_in_s;
	logic                   pd_s;
	logic [NUM_PINS-1:0]    pin_in_s;
	logic                   sclk_prev_r;
	logic                   sclk_rise;
	logic                   sclk_fall;
	logic                   selected;

	// Serial engine
	rrp_state_type          state_r;
	rrp_state_type          state_nxt;
	logic [BIT_CNT_W-1:0]   bit_cnt_r;
	logic [DATA_W-1:0]      cmd_r;
	logic [ADDR_W-1:0]      addr_r;
	logic                   write_r;
	logic [DATA_W-1:0]      wr_shift_r;
	logic [DATA_W-1:0]      rd_shift_r;
	logic                   load_rd;
	logic [ADDR_W-1:0]      load_addr;
	logic                   load_is_read;
	logic                   do_write;
	logic [DATA_W-1:0]      wr_data;

	// Registers
	logic [DATA_W-1:0]      cause_first_r;
	logic [DATA_W-1:0]      cause_second_r;
	logic [DATA_W-1:0]      enable_first_r;
	logic [DATA_W-1:0]      enable_second_r;
	logic [NUM_PINS-1:0][DATA_W-1:0] pin_cfg_r;
	logic                   clr_first;
	logic                   clr_second;
	logic [POR_CNT_W-1:0]   por_cnt_r;

	// Index of a pin configuration register, NUM_PINS if none
	function automatic int cfg_index(input logic [ADDR_W-1:0] a);
		int idx;
		idx = NUM_PINS;
		if (a == ADDR_PIN0_CFG) idx = 0;
		if (a == ADDR_PIN1_CFG) idx = 1;
		if (a == ADDR_PIN2_CFG) idx = 2;
		return idx;
	endfunction

	// Read decode; unmapped addresses read as zero
	function automatic logic [DATA_W-1:0] read_value(input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] v;
		int                idx;
		v   = READ_NONE;
		idx = cfg_index(a);
		if (idx < NUM_PINS) v = pin_cfg_r[idx];
		if (a == ADDR_CAUSE_FIRST) v = cause_first_r;
		if (a == ADDR_CAUSE_SECOND) v = cause_second_r;
		if (a == ADDR_ENABLE_FIRST) v = enable_first_r;
		if (a == ADDR_ENABLE_SECOND) v = enable_second_r;
		if (a == ADDR_PIN_STATE) v = DATA_W'(pin_in_s);
		return v;
	endfunction

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_pipe_r <= 2'b00;
		end else begin
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe_r[1];

	// Host pins arrive on their own timing
	rrp_sync #(
		.WIDTH   (4),
		.RST_VAL (SERIAL_SYNC_RST)
	) u_serial_sync (
		.clock_i  (clock_i),
		.rst_n_i  (rst_n),
		.clk_en_i (clk_en_i),
		.d_i      ({serial_i.select_n, serial_i.sclk, serial_i.write_in, power_down_in_i}),
		.q_o      ({sel_n_s, sclk_s, write_in_s, pd_s})
	);

	// Pin read-back, sampled like any outside input
	rrp_sync #(
		.WIDTH   (NUM_PINS),
		.RST_VAL ('0)
	) u_pin_sync (
		.clock_i  (clock_i),
		.rst_n_i  (rst_n),
		.clk_en_i (clk_en_i),
		.d_i      (gpio_in_i),
		.q_o      (pin_in_s)
	);

	// Serial clock edge finder; sclk is far slower than the core clock
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_r <= 1'b0;
		end else if (clk_en_i) begin
			sclk_prev_r <= sclk_s;
		end
	end
	assign sclk_rise = sclk_s & ~sclk_prev_r;
	assign sclk_fall = ~sclk_s & sclk_prev_r;
	assign selected  = ~sel_n_s & ~pd_s;

	// Engine next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (selected) state_nxt = ST_ADDR;
			end
			ST_ADDR: begin
				if (!selected) state_nxt = ST_IDLE;
				else if (sclk_rise && bit_cnt_r == ADDR_LAST_BIT) state_nxt = ST_DATA;
			end
			ST_DATA: begin
				// Burst: stays in data until select rises or power-down is asserted
				if (!selected) state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
		end else if (clk_en_i) begin
			state_r <= state_nxt;
		end
	end

	// Bit counter wraps back to the data field for bursts
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_r <= '0;
		end else if (clk_en_i) begin
			if (!selected) begin
				bit_cnt_r <= '0;
			end else if (sclk_rise) begin
				if (bit_cnt_r == DATA_LAST_BIT) bit_cnt_r <= DATA_FIRST_BIT;
				else bit_cnt_r <= bit_cnt_r + 1'b1;
			end
		end
	end

	// Command byte, then data bytes, all on rising sclk
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			cmd_r      <= '0;
			wr_shift_r <= '0;
		end else if (clk_en_i && selected && sclk_rise) begin
			if (state_r == ST_ADDR) cmd_r <= {cmd_r[DATA_W-2:0], write_in_s};
			if (state_r == ST_DATA) wr_shift_r <= {wr_shift_r[DATA_W-2:0], write_in_s};
		end
	end

	// Completed-byte decode
	assign wr_data      = {wr_shift_r[DATA_W-2:0], write_in_s};
	assign load_rd      = selected && sclk_rise
	                      && ((state_r == ST_ADDR && bit_cnt_r == ADDR_LAST_BIT)
	                      || (state_r == ST_DATA && bit_cnt_r == DATA_LAST_BIT));
	assign load_addr    = (state_r == ST_ADDR) ? {cmd_r[ADDR_W-2:0], write_in_s}
	                                           : addr_r + 1'b1;
	assign load_is_read = (state_r == ST_ADDR) ? (cmd_r[DIR_BIT_POS] != DIR_WRITE) : ~write_r;
	assign do_write     = selected && sclk_rise && state_r == ST_DATA
	                      && bit_cnt_r == DATA_LAST_BIT && write_r;

	// Address and direction; burst steps to the next register
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			addr_r  <= '0;
			write_r <= 1'b0;
		end else if (clk_en_i) begin
			if (selected && sclk_rise && state_r == ST_ADDR && bit_cnt_r == ADDR_LAST_BIT) begin
				addr_r  <= load_addr;
				write_r <= (cmd_r[DIR_BIT_POS] == DIR_WRITE);
			end else if (do_write || (load_rd && state_r == ST_DATA)) begin
				addr_r  <= addr_r + 1'b1;
			end
		end
	end

	// Read data loaded at byte boundary, shifted out on falling sclk
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_shift_r            <= '0;
			serial_readback_out_o <= 1'b0;
			serial_readback_oe_o  <= 1'b0;
		end else if (clk_en_i) begin
			serial_readback_oe_o <= selected;
			if (!selected) begin
				serial_readback_out_o <= 1'b0;
			end else if (load_rd) begin
				rd_shift_r <= load_is_read ? read_value(load_addr) : READ_NONE;
			end else if (sclk_fall && state_r == ST_DATA) begin
				serial_readback_out_o <= rd_shift_r[DATA_W-1];
				rd_shift_r            <= {rd_shift_r[DATA_W-2:0], 1'b0};
			end
		end
	end

	// Reading a cause register clears it
	assign clr_first  = load_rd && load_is_read && load_addr == ADDR_CAUSE_FIRST;
	assign clr_second = load_rd && load_is_read && load_addr == ADDR_CAUSE_SECOND;

	// Sticky causes; a new event in the clearing cycle survives
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			cause_first_r  <= '0;
			cause_second_r <= '0;
		end else if (clk_en_i) begin
			if (pd_s) begin
				cause_first_r  <= '0;
				cause_second_r <= '0;
			end else begin
				cause_first_r  <= (cause_first_r & ~{DATA_W{clr_first}})
				                  | event_i[DATA_W-1:0];
				cause_second_r <= (cause_second_r & ~{DATA_W{clr_second}})
				                  | event_i[EVENT_W-1:DATA_W];
			end
		end
	end

	// Host-written enables and pin configuration
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			enable_first_r  <= RST_ENABLE;
			enable_second_r <= RST_ENABLE;
			pin_cfg_r       <= RST_PIN_CFG;
		end else if (clk_en_i) begin
			if (pd_s) begin
				enable_first_r  <= RST_ENABLE;
				enable_second_r <= RST_ENABLE;
				pin_cfg_r       <= RST_PIN_CFG;
			end else if (do_write) begin
				if (addr_r == ADDR_ENABLE_FIRST) enable_first_r <= wr_data;
				if (addr_r == ADDR_ENABLE_SECOND) enable_second_r <= wr_data;
				for (int p = 0; p < NUM_PINS; p++) begin
					if (cfg_index(addr_r) == p) pin_cfg_r[p] <= wr_data;
				end
			end
		end
	end

	// Interrupt line low while any enabled cause is pending
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			host_interrupt_n_o <= 1'b1;
		end else if (clk_en_i) begin
			host_interrupt_n_o <= ~(|(cause_first_r & enable_first_r)
			                      | |(cause_second_r & enable_second_r));
		end
	end

	// Power-on indication after reset or power-down release
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			por_cnt_r <= POR_CNT_W'(POR_HOLD);
		end else if (clk_en_i) begin
			if (pd_s) por_cnt_r <= POR_CNT_W'(POR_HOLD);
			else if (por_cnt_r != '0) por_cnt_r <= por_cnt_r - 1'b1;
		end
	end

	// Pin drivers go quiet during power-down
	rrp_pin_mux #(
		.MCU_HALF (MCU_HALF)
	) u_pin_mux (
		.clock_i       (clock_i),
		.rst_n_i       (rst_n),
		.clk_en_i      (clk_en_i),
		.quiet_i       (pd_s),
		.cfg_i         (pin_cfg_r),
		.por_active_i  (por_cnt_r != '0),
		.fifo_status_i (fifo_status_i),
		.wake_timer_i  (wake_timer_i),
		.low_batt_i    (low_batt_i),
		.drive_o       (gpio_o)
	);

endmodule

// [tb/rrp_host_port_sva.sv]
module rrp_host_port_sva
	import rrp_pkg::*;
#(
	parameter int POR_HOLD = POR_CYCLES,
	parameter int MCU_HALF = MCU_CLK_HALF
) (
	// Clock and reset
	input  wire logic                        clock_i,
	input  wire logic                        rst_b_i,
	input  wire logic                        clk_en_i,
	// Host side
	input  rrp_pkg::rrp_serial_in_type       serial_i,
	input  wire logic                        serial_readback_out_o,
	input  wire logic                        serial_readback_oe_o,
	input  wire logic                        host_interrupt_n_o,
	input  wire logic                        power_down_in_i,
	// Pins and sources
	input  wire logic [rrp_pkg::NUM_PINS-1:0] gpio_in_i,
	input  rrp_pkg::rrp_pin_drive_type       gpio_o,
	input  wire logic [rrp_pkg::EVENT_W-1:0] event_i,
	input  wire logic                        fifo_status_i,
	input  wire logic                        wake_timer_i,
	input  wire logic                        low_batt_i
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [3:0] evt_age_r;
	logic [3:0] quiet_r;

	// Age since an event or frame; a frame may change the enables too
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i)
			evt_age_r <= 4'h0;
		else if (event_i != '0 || !serial_i.select_n)
			evt_age_r <= 4'h0;
		else if (evt_age_r != 4'hF)
			evt_age_r <= evt_age_r + 4'h1;
	end

	// Age since anything that may legally move pins or clear the interrupt
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i)
			quiet_r <= 4'h0;
		else if (!serial_i.select_n || power_down_in_i)
			quiet_r <= 4'h0;
		else if (quiet_r != 4'hF)
			quiet_r <= quiet_r + 4'h1;
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);

	oe_rise_a: assert property (
		$fell(serial_i.select_n) && !power_down_in_i |-> ##[1:5] serial_readback_oe_o)
		else $error("readback enable missing after select");
	oe_drop_a: assert property (
		$rose(serial_i.select_n) |-> ##[1:5] !serial_readback_oe_o)
		else $error("readback enable stuck after deselect");
	readback_quiet_a: assert property (
		!serial_readback_oe_o && $past(!serial_readback_oe_o) |-> !serial_readback_out_o)
		else $error("readback active while deselected");
	readback_hold_a: assert property (
		serial_readback_oe_o && $past(serial_readback_oe_o) && $changed(serial_readback_out_o)
		|-> !serial_i.sclk)
		else $error("readback moved during clock high phase");
	pd_quiet_a: assert property (
		power_down_in_i [*5] |-> !serial_readback_oe_o && host_interrupt_n_o && gpio_o.enable == '0)
		else $error("outputs active in power down");
	rst_out_a: assert property (
		$rose(rst_b_i) |-> host_interrupt_n_o && !serial_readback_oe_o)
		else $error("outputs not at reset level");
	irq_cause_a: assert property (
		$fell(host_interrupt_n_o) |-> evt_age_r < 4'h4)
		else $error("interrupt without event");
	irq_clear_a: assert property (
		$rose(host_interrupt_n_o) |-> quiet_r < 4'h4)
		else $error("interrupt released without access");
	pins_stable_a: assert property (
		quiet_r > 4'h8 |-> $stable(gpio_o.enable))
		else $error("pin enable moved without configuration");

	// Main scenarios reached
	cover property ($fell(host_interrupt_n_o));
	cover property ($rose(serial_readback_oe_o));
	cover property ($rose(power_down_in_i));
endmodule

bind rrp_host_port rrp_host_port_sva #(.POR_HOLD(POR_HOLD), .MCU_HALF(MCU_HALF)) i_rrp_host_port_sva (
	.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i), .serial_i(serial_i),
	.serial_readback_out_o(serial_readback_out_o), .serial_readback_oe_o(serial_readback_oe_o),
	.host_interrupt_n_o(host_interrupt_n_o), .power_down_in_i(power_down_in_i),
	.gpio_in_i(gpio_in_i), .gpio_o(gpio_o), .event_i(event_i), .fifo_status_i(fifo_status_i),
	.wake_timer_i(wake_timer_i), .low_batt_i(low_batt_i));

// [tb/rrp_host_model.sv]
module rrp_host_model
	import rrp_pkg::*;
(
	// Clock and readback
	input  wire logic                  clock_i,
	input  wire logic                  readback_i,
	// Serial pins to the device
	output rrp_pkg::rrp_serial_in_type serial_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle: deselected, serial clock parked low
	initial begin
		serial_o = '{select_n: 1'b1, sclk: 1'b0, write_in: 1'b0};
	end

	// One framed transfer of nb bytes; 25 core clocks per serial clock
	task automatic frame(input logic wr, input logic [6:0] addr, input int nb,
		input logic [31:0] wdata, output logic [31:0] rdata);
		logic [39:0] bits;
		bits = {wr, addr, wdata << (8 * (4 - nb))};
		rdata = '0;
		@(negedge clock_i);
		serial_o.select_n = 1'b0;
		for (int i = 0; i < 8 + 8 * nb; i++) begin
			serial_o.write_in = bits[39 - i];
			repeat (12) @(negedge clock_i);
			serial_o.sclk = 1'b1;
			if (i >= 8)
				rdata = {rdata[30:0], readback_i};
			repeat (12) @(negedge clock_i);
			serial_o.sclk = 1'b0;
			@(negedge clock_i);
		end
		repeat (12) @(negedge clock_i);
		serial_o.select_n = 1'b1;
		// Released data line must not keep its last level
		serial_o.write_in = ~serial_o.write_in;
		repeat (12) @(negedge clock_i);
	endtask
endmodule

// [tb/rrp_host_port_tb_top.sv]
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end

module rrp_host_port_tb_top
	import rrp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int POR_SIM = 8;
	logic                       clock_i;
	logic                       rst_b_i;
	logic                       clk_en;
	logic                       power_down;
	logic                       rb_out;
	logic                       irq_n;
	logic [EVENT_W-1:0]         event_v;
	logic                       fifo;
	logic                       wake;
	logic                       lowbat;
	logic [31:0]                rdv;
	logic                       lv1;
	rrp_serial_in_type          serial;
	rrp_pin_drive_type          gpio;
	int                         mismatches;
	int                         samples_checked;
	logic [2:0]                 fn [6];

	// Core clock, 200 MHz
	initial clock_i = 1'b0;
	always #2.5 clock_i = ~clock_i;

	rrp_host_port #(.POR_HOLD(POR_SIM)) i_rrp_host_port (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en), .serial_i(serial),
		.serial_readback_out_o(rb_out), .serial_readback_oe_o(), .host_interrupt_n_o(irq_n),
		.power_down_in_i(power_down), .gpio_in_i(3'h5), .gpio_o(gpio), .event_i(event_v),
		.fifo_status_i(fifo), .wake_timer_i(wake), .low_batt_i(lowbat));

	rrp_host_model i_rrp_host_model (.clock_i(clock_i), .readback_i(rb_out), .serial_o(serial));

	// Verdict and end of run
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic wr(input logic [6:0] a, input int nb, input logic [31:0] d);
		i_rrp_host_model.frame(1'b1, a, nb, d, rdv);
	endtask

	task automatic rd(input logic [6:0] a, input int nb, input logic [31:0] e);
		i_rrp_host_model.frame(1'b0, a, nb, 32'h0, rdv);
		`CHK(rdv, e);
	endtask

	// One-cycle internal event pulse
	task automatic pulse(input logic [EVENT_W-1:0] e);
		@(negedge clock_i);
		event_v = e;
		@(negedge clock_i);
		event_v = '0;
	endtask

	// Bounded wait for the interrupt; a timeout ends the run
	task automatic wait_irq();
		for (int n = 0; n < 10 && irq_n !== 1'b0; n++)
			@(negedge clock_i);
		`CHK(irq_n, 1'b0);
		if (irq_n !== 1'b0)
			conclude();
	endtask

	// Watchdog against a hung run
	initial begin
		#400000;
		mismatches++;
		conclude();
	end

	initial begin
		mismatches = 0;
		samples_checked = 0;
		rst_b_i = 1'b0;
		clk_en = 1'b1;
		power_down = 1'b0;
		event_v = '0;
		fifo = 1'b1;
		wake = 1'b0;
		lowbat = 1'b1;
		fn = '{FUNC_WAKE, FUNC_LOWBAT, FUNC_FIFO, FUNC_DRV0, FUNC_DRV1, FUNC_INPUT};
		repeat (12) @(negedge clock_i);
		rst_b_i = 1'b1;
		repeat (POR_SIM + 20) @(negedge clock_i);

		rd(ADDR_PIN0_CFG, 3, {RST_PIN_CFG[0], RST_PIN_CFG[1], RST_PIN_CFG[2]});
		rd(ADDR_ENABLE_FIRST, 2, {RST_ENABLE, RST_ENABLE});
		`CHK(gpio.enable[2], 1'b0);
		lv1 = gpio.level[1];
		repeat (MCU_CLK_HALF) @(negedge clock_i);
		`CHK(gpio.level[1], ~lv1);
		// Enable low freezes the divider, so the pin clock must hold its level
		clk_en = 1'b0;
		lv1 = gpio.level[1];
		repeat (3 * MCU_CLK_HALF) @(negedge clock_i);
		`CHK(gpio.level[1], lv1);
		clk_en = 1'b1;
		$display("test reset_values done");

		for (int i = 0; i < 6; i++) begin
			wr(ADDR_PIN0_CFG, 1, {29'h0, fn[i]});
			`CHK(gpio.enable[0], i < 5);
			if (i < 5)
				`CHK(gpio.level[0], (5'b10110 >> i) & 1'b1);
		end
		wr(ADDR_PIN0_CFG, 3, 32'h00F5E607);
		rd(ADDR_PIN0_CFG, 3, 32'h00F5E607);
		`CHK(gpio.enable, 3'h3);
		`CHK(gpio.level[1:0], 2'h2);
		$display("test pin_functions done");

		wr(ADDR_CAUSE_FIRST, 1, 32'hFF);
		rd(ADDR_CAUSE_FIRST, 2, 32'h0);
		rd(7'h20, 1, {24'h0, READ_NONE});
		rd(ADDR_PIN_STATE, 1, 32'h05);
		$display("test refused_access done");

		wr(ADDR_ENABLE_FIRST, 2, 32'h0180);
		pulse(16'h0002);
		repeat (6) @(negedge clock_i);
		`CHK(irq_n, 1'b1);
		pulse(16'h0001);
		wait_irq();
		rd(ADDR_CAUSE_FIRST, 1, 32'h03);
		`CHK(irq_n, 1'b1);
		pulse(16'h8000);
		wait_irq();
		rd(ADDR_CAUSE_SECOND, 1, 32'h80);
		`CHK(irq_n, 1'b1);
		rd(ADDR_CAUSE_FIRST, 1, 32'h0);
		$display("test interrupts done");

		pulse(16'h0001);
		wait_irq();
		power_down = 1'b1;
		repeat (10) @(negedge clock_i);
		`CHK(irq_n, 1'b1);
		`CHK(gpio.enable, 3'h0);
		power_down = 1'b0;
		// Pin 0 is back on its power-on function: high for the hold time
		repeat (4) @(negedge clock_i);
		`CHK(gpio.enable[0], 1'b1);
		`CHK(gpio.level[0], 1'b1);
		repeat (POR_SIM + 16) @(negedge clock_i);
		`CHK(gpio.level[0], 1'b0);
		rd(ADDR_PIN0_CFG, 2, {RST_PIN_CFG[0], RST_PIN_CFG[1]});
		rd(ADDR_ENABLE_FIRST, 1, RST_ENABLE);
		pulse(16'h0001);
		repeat (6) @(negedge clock_i);
		`CHK(irq_n, 1'b1);
		$display("test power_down done");
		conclude();
	end
endmodule
